// ---- rtl/fsa_pkg.sv ----
// Constants shared by the frequency-locked-loop averaging control block
package fsa_pkg;
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] REG_COMMAND     = 8'h00;
   localparam logic [7:0] REG_STATUS      = 8'h04;
   localparam logic [7:0] REG_DAC         = 8'h08;
   localparam logic [7:0] REG_ACCUM       = 8'h0C;
   localparam logic [7:0] REG_SAMPLE      = 8'h10;
   localparam logic [7:0] REG_CYCLE_SIZE  = 8'h14;
   localparam logic [7:0] REG_LOCK_LIMIT  = 8'h18;
   localparam logic [7:0] REG_VERSION     = 8'h1C;
   localparam int         ADDR_LSB        = 0;
   localparam int         ADDR_MSB        = 7;

   // Command register fields
   localparam int         CMD_OP_LSB      = 16;
   localparam int         CMD_OP_MSB      = 23;
   localparam int         CMD_ARG_LSB     = 0;
   localparam int         CMD_ARG_MSB     = 15;

   // Command operation codes
   localparam logic [7:0] SLOPE_POSITIVE_CMD     = 8'h01;
   localparam logic [7:0] SLOPE_NEGATIVE_CMD     = 8'h02;
   localparam logic [7:0] OUTPUT_GATING_OFF_CMD  = 8'h03;
   localparam logic [7:0] OUTPUT_GATING_ON_CMD   = 8'h04;
   localparam logic [7:0] VOTING_MODE_CMD        = 8'h05;
   localparam logic [7:0] SUMMING_MODE_CMD       = 8'h06;
   localparam logic [7:0] DISABLE_CMD            = 8'h07;
   localparam logic [7:0] ENABLE_CMD             = 8'h08;
   localparam logic [7:0] TUNE_CMD               = 8'h09;

   // Status register bit positions
   localparam int         ST_LOCKED_BIT   = 0;
   localparam int         ST_DISABLED_BIT = 1;
   localparam int         ST_SLOPE_BIT    = 2;
   localparam int         ST_SUMMING_BIT  = 3;
   localparam int         ST_GATING_BIT   = 4;
   localparam int         ST_SETTLE_BIT   = 5;
   localparam int         ST_PROMPT_BIT   = 6;

   // Nominal sample count and defaults
   localparam logic [15:0] NOMINAL_COUNT      = 16'h6800;
   localparam logic [15:0] DEFAULT_CYCLE_SIZE = 16'h000A;
   localparam logic [15:0] DEFAULT_LOCK_LIMIT = 16'h0002;
   localparam logic [15:0] DAC_MID_SCALE      = 16'h0200;
   localparam logic [15:0] DAC_STEP           = 16'h0001;
   localparam logic [7:0]  FW_VERSION         = 8'h11;  // Arbitrary value

   // Timing, clock at 100 MHz
   localparam longint unsigned CLK_PERIOD_NS    = 64'd10;
   localparam longint unsigned POWERUP_TIME_MS  = 64'd1000;
   localparam longint unsigned SAMPLE_TIME_S    = 64'd16;
   localparam longint unsigned SETTLE_TIME_S    = 64'd16;
   localparam longint unsigned POWERUP_CYCLES   =
      POWERUP_TIME_MS * 64'd1000000 / CLK_PERIOD_NS;
   localparam longint unsigned SAMPLE_CYCLES    =
      SAMPLE_TIME_S * 64'd1000000000 / CLK_PERIOD_NS;
   localparam longint unsigned SETTLE_CYCLES    =
      SETTLE_TIME_S * 64'd1000000000 / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      SEQ_POWER_WAIT,
      SEQ_PROMPT,
      SEQ_LOAD,
      SEQ_SAMPLE,
      SEQ_EVAL,
      SEQ_SETTLE,
      SEQ_DISABLED
   } fsa_seq_type;
endpackage : fsa_pkg

// ---- rtl/fsa_sample_window.sv ----
// Counts reference ticks over one fixed measurement window
`timescale 1ns/1ns
`default_nettype none
module fsa_sample_window #(
   parameter int unsigned WINDOW_CYCLES = 32'(fsa_pkg::SAMPLE_CYCLES),
   parameter int unsigned CW            = 16
) (
   input  wire logic          hclk,
   input  wire logic          hresetn,
   input  wire logic          ce,
   input  wire logic          start,
   input  wire logic          ref_tick,
   output logic               done,
   output logic [CW-1:0]      count
);
   logic          run_r;
   logic [31:0]   timer_r;
   logic [CW-1:0] ticks_r;
   wire           last = run_r && (timer_r == 32'(WINDOW_CYCLES - 1));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run_r   <= 1'b0;
         timer_r <= 32'h0;
         ticks_r <= '0;
         done    <= 1'b0;
         count   <= '0;
      end else if (ce) begin
         done <= last && !start;
         if (start) begin
            run_r   <= 1'b1;
            timer_r <= 32'h0;
            ticks_r <= '0;
         end else if (run_r) begin
            timer_r <= timer_r + 32'h1;
            ticks_r <= ticks_r + CW'(ref_tick);
            if (last) begin
               run_r <= 1'b0;
               count <= ticks_r + CW'(ref_tick);
            end
         end
      end
   end
endmodule : fsa_sample_window
`default_nettype wire

// ---- rtl/fsa_core.sv ----
// Frequency-locked-loop sample averaging control with AHB-Lite registers
//
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module fsa_core #(
   parameter int unsigned POWERUP_CYCLES = 32'(fsa_pkg::POWERUP_CYCLES),
   parameter int unsigned SAMPLE_CYCLES  = 32'(fsa_pkg::SAMPLE_CYCLES),
   parameter int unsigned SETTLE_CYCLES  = 32'(fsa_pkg::SETTLE_CYCLES),
   parameter int unsigned DAC_W          = 10
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             ce,
   input  wire logic             hsel,
   input  wire logic [31:0]      haddr,
   input  wire logic [1:0]       htrans,
   input  wire logic             hwrite,
   input  wire logic [2:0]       hsize,
   input  wire logic [31:0]      hwdata,
   input  wire logic             hready,
   output logic      [31:0]      hrdata,
   output logic                  hreadyout,
   output logic                  hresp,
   input  wire logic             ref_tick,
   input  wire logic             nv_valid,
   input  wire logic             nv_slope_neg,
   input  wire logic             nv_summing,
   input  wire logic             nv_gating_on,
   input  wire logic [15:0]      nv_cycle_size,
   input  wire logic [15:0]      nv_lock_limit,
   input  wire logic [DAC_W-1:0] nv_dac,
   output logic      [DAC_W-1:0] dac_value,
   output logic                  dac_load,
   output logic                  ref_out_enable,
   output logic                  prompt_valid,
   output logic      [7:0]       prompt_data
);
   localparam logic [DAC_W-1:0] DAC_MAX = '1;

   fsa_pkg::fsa_seq_type seq_r, seq_nxt;
   logic [31:0]      timer_r, timer_nxt;
   logic [31:0]      acc_r, acc_nxt;
   logic [15:0]      cnt_r, cnt_nxt;
   logic [15:0]      size_r, size_nxt;
   logic [15:0]      limit_r, limit_nxt;
   logic [15:0]      last_sample_r, last_sample_nxt;
   logic [DAC_W-1:0] dac_nxt;
   logic             locked_r, locked_nxt;
   logic             slope_neg_r, slope_neg_nxt;
   logic             summing_r, summing_nxt;
   logic             gating_r, gating_nxt;
   logic             prompted_r, prompted_nxt;
   logic             start_r, start_nxt;
   logic             dac_load_nxt;
   logic             prompt_nxt;
   logic             wr_pend_r;
   logic [7:0]       wr_addr_r;

   // Window sampler
   wire              smp_done;
   wire [15:0]       smp_count;

   fsa_sample_window #(
      .WINDOW_CYCLES (SAMPLE_CYCLES),
      .CW            (16)
   ) u_window (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .ce       (ce),
      .start    (start_r),
      .ref_tick (ref_tick),
      .done     (smp_done),
      .count    (smp_count)
   );

   // AHB-Lite decode; every access is zero wait state and OKAY
   wire              addr_phase = hsel && hready && htrans[1];
   wire [7:0]        rd_addr    = haddr[fsa_pkg::ADDR_MSB:fsa_pkg::ADDR_LSB];
   wire              wr_cmd     = wr_pend_r && (wr_addr_r == fsa_pkg::REG_COMMAND);
   wire              wr_size    = wr_pend_r && (wr_addr_r == fsa_pkg::REG_CYCLE_SIZE);
   wire              wr_limit   = wr_pend_r && (wr_addr_r == fsa_pkg::REG_LOCK_LIMIT);
   wire [7:0]        cmd_op     = hwdata[fsa_pkg::CMD_OP_MSB:fsa_pkg::CMD_OP_LSB];
   wire [15:0]       cmd_arg    = hwdata[fsa_pkg::CMD_ARG_MSB:fsa_pkg::CMD_ARG_LSB];
   wire              is_cmd_op  = wr_cmd;

   wire [31:0]       status_word = {25'h0,
                                    prompted_r,
                                    seq_r == fsa_pkg::SEQ_SETTLE,
                                    gating_r,
                                    summing_r,
                                    slope_neg_r,
                                    seq_r == fsa_pkg::SEQ_DISABLED,
                                    locked_r};
   wire [31:0]       rd_mux =
      (rd_addr == fsa_pkg::REG_STATUS)     ? status_word :
      (rd_addr == fsa_pkg::REG_DAC)        ? 32'(dac_value) :
      (rd_addr == fsa_pkg::REG_ACCUM)      ? acc_r :
      (rd_addr == fsa_pkg::REG_SAMPLE)     ? {cnt_r, last_sample_r} :
      (rd_addr == fsa_pkg::REG_CYCLE_SIZE) ? {16'h0, size_r} :
      (rd_addr == fsa_pkg::REG_LOCK_LIMIT) ? {16'h0, limit_r} :
      (rd_addr == fsa_pkg::REG_VERSION)    ? {24'h0, fsa_pkg::FW_VERSION} :
      32'h0;

   // Sample difference and per-mode accumulator step
   wire [31:0]       sample_diff = 32'($signed({1'b0, smp_count})) -
                                   32'($signed({1'b0, fsa_pkg::NOMINAL_COUNT}));
   wire              above_nom   = smp_count > fsa_pkg::NOMINAL_COUNT;
   wire              below_nom   = smp_count < fsa_pkg::NOMINAL_COUNT;
   wire [31:0]       vote_step   = above_nom ? 32'h1 :
                                   below_nom ? 32'hFFFF_FFFF :
                                   32'h0;
   wire [31:0]       acc_step    = summing_r ? sample_diff : vote_step;
   wire [15:0]       cnt_inc     = cnt_r + 16'h1;
   wire              cycle_full  = cnt_inc >= size_r;

   // Correction: negative accumulator means oscillator runs slow
   wire              acc_neg     = acc_r[31];
   wire              acc_zero    = (acc_r == 32'h0);
   wire [31:0]       acc_abs     = acc_neg ? (32'h0 - acc_r) : acc_r;
   wire              dac_up      = acc_neg ^ slope_neg_r;
   wire [DAC_W-1:0]  dac_step    = DAC_W'(fsa_pkg::DAC_STEP);
   wire [DAC_W-1:0]  dac_raised  = (dac_value > DAC_MAX - dac_step) ? DAC_MAX :
                                   dac_value + dac_step;
   wire [DAC_W-1:0]  dac_lowered = (dac_value < dac_step) ? '0 :
                                   dac_value - dac_step;
   wire              settle_end  = timer_r == 32'(SETTLE_CYCLES - 1);
   wire              power_end   = timer_r == 32'(POWERUP_CYCLES - 1);
   wire              running     = seq_r == fsa_pkg::SEQ_SAMPLE ||
                                   seq_r == fsa_pkg::SEQ_EVAL ||
                                   seq_r == fsa_pkg::SEQ_SETTLE;

   always_comb begin
      seq_nxt         = seq_r;
      timer_nxt       = timer_r;
      acc_nxt         = acc_r;
      cnt_nxt         = cnt_r;
      size_nxt        = size_r;
      limit_nxt       = limit_r;
      last_sample_nxt = last_sample_r;
      dac_nxt         = dac_value;
      locked_nxt      = locked_r;
      slope_neg_nxt   = slope_neg_r;
      summing_nxt     = summing_r;
      gating_nxt      = gating_r;
      prompted_nxt    = prompted_r;
      start_nxt       = 1'b0;
      dac_load_nxt    = 1'b0;
      prompt_nxt      = 1'b0;

      unique case (seq_r)
         fsa_pkg::SEQ_POWER_WAIT: begin
            timer_nxt = timer_r + 32'h1;
            if (power_end) begin
               seq_nxt   = fsa_pkg::SEQ_PROMPT;
               timer_nxt = 32'h0;
            end
         end
         fsa_pkg::SEQ_PROMPT: begin
            prompt_nxt   = 1'b1;
            prompted_nxt = 1'b1;
            seq_nxt      = fsa_pkg::SEQ_LOAD;
         end
         fsa_pkg::SEQ_LOAD: begin
            if (nv_valid) begin
               slope_neg_nxt = nv_slope_neg;
               summing_nxt   = nv_summing;
               gating_nxt    = nv_gating_on;
               size_nxt      = nv_cycle_size;
               limit_nxt     = nv_lock_limit;
               dac_nxt       = nv_dac;
            end else begin
               slope_neg_nxt = 1'b0;
               summing_nxt   = 1'b0;
               gating_nxt    = 1'b0;
               size_nxt      = fsa_pkg::DEFAULT_CYCLE_SIZE;
               limit_nxt     = fsa_pkg::DEFAULT_LOCK_LIMIT;
               dac_nxt       = DAC_W'(fsa_pkg::DAC_MID_SCALE);
            end
            dac_load_nxt = 1'b1;
            locked_nxt   = 1'b0;
            acc_nxt      = 32'h0;
            cnt_nxt      = 16'h0;
            start_nxt    = 1'b1;
            seq_nxt      = fsa_pkg::SEQ_SAMPLE;
         end
         fsa_pkg::SEQ_SAMPLE: begin
            if (smp_done) begin
               acc_nxt         = acc_r + acc_step;
               cnt_nxt         = cnt_inc;
               last_sample_nxt = smp_count;
               if (cycle_full) begin
                  seq_nxt = fsa_pkg::SEQ_EVAL;
               end else begin
                  start_nxt = 1'b1;
               end
            end
         end
         fsa_pkg::SEQ_EVAL: begin
            locked_nxt = acc_abs < 32'(limit_r);
            if (!acc_zero) begin
               dac_nxt      = dac_up ? dac_raised : dac_lowered;
               dac_load_nxt = 1'b1;
               timer_nxt    = 32'h0;
               seq_nxt      = fsa_pkg::SEQ_SETTLE;
            end else begin
               acc_nxt   = 32'h0;
               cnt_nxt   = 16'h0;
               start_nxt = 1'b1;
               seq_nxt   = fsa_pkg::SEQ_SAMPLE;
            end
         end
         fsa_pkg::SEQ_SETTLE: begin
            timer_nxt = timer_r + 32'h1;
            if (settle_end) begin
               acc_nxt   = 32'h0;
               cnt_nxt   = 16'h0;
               start_nxt = 1'b1;
               seq_nxt   = fsa_pkg::SEQ_SAMPLE;
            end
         end
         fsa_pkg::SEQ_DISABLED: begin
            if (is_cmd_op && cmd_op == fsa_pkg::TUNE_CMD) begin
               dac_nxt      = cmd_arg[DAC_W-1:0];
               dac_load_nxt = 1'b1;
            end
            if (is_cmd_op && cmd_op == fsa_pkg::ENABLE_CMD) begin
               locked_nxt = 1'b0;
               acc_nxt    = 32'h0;
               cnt_nxt    = 16'h0;
               start_nxt  = 1'b1;
               seq_nxt    = fsa_pkg::SEQ_SAMPLE;
            end
         end
         default: begin
            seq_nxt = fsa_pkg::SEQ_POWER_WAIT;
         end
      endcase

      // Software setting changes apply from the next cycle on
      if (wr_size) begin
         size_nxt = hwdata[15:0];
      end
      if (wr_limit) begin
         limit_nxt = hwdata[15:0];
      end
      if (is_cmd_op) begin
         unique case (cmd_op)
            fsa_pkg::SLOPE_POSITIVE_CMD:    slope_neg_nxt = 1'b0;
            fsa_pkg::SLOPE_NEGATIVE_CMD:    slope_neg_nxt = 1'b1;
            fsa_pkg::OUTPUT_GATING_OFF_CMD: gating_nxt    = 1'b0;
            fsa_pkg::OUTPUT_GATING_ON_CMD:  gating_nxt    = 1'b1;
            fsa_pkg::VOTING_MODE_CMD:       summing_nxt   = 1'b0;
            fsa_pkg::SUMMING_MODE_CMD:      summing_nxt   = 1'b1;
            fsa_pkg::DISABLE_CMD: begin
               if (running) begin
                  seq_nxt    = fsa_pkg::SEQ_DISABLED;
                  locked_nxt = 1'b0;
                  start_nxt  = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // Bus slave flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h0;
         hrdata    <= 32'h0;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (ce) begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= rd_addr;
         if (addr_phase && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Loop control flops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seq_r         <= fsa_pkg::SEQ_POWER_WAIT;
         timer_r       <= 32'h0;
         acc_r         <= 32'h0;
         cnt_r         <= 16'h0;
         size_r        <= fsa_pkg::DEFAULT_CYCLE_SIZE;
         limit_r       <= fsa_pkg::DEFAULT_LOCK_LIMIT;
         last_sample_r <= 16'h0;
         dac_value     <= DAC_W'(fsa_pkg::DAC_MID_SCALE);
         locked_r      <= 1'b0;
         slope_neg_r   <= 1'b0;
         summing_r     <= 1'b0;
         gating_r      <= 1'b0;
         prompted_r    <= 1'b0;
         start_r       <= 1'b0;
      end else if (ce) begin
         seq_r         <= seq_nxt;
         timer_r       <= timer_nxt;
         acc_r         <= acc_nxt;
         cnt_r         <= cnt_nxt;
         size_r        <= size_nxt;
         limit_r       <= limit_nxt;
         last_sample_r <= last_sample_nxt;
         dac_value     <= dac_nxt;
         locked_r      <= locked_nxt;
         slope_neg_r   <= slope_neg_nxt;
         summing_r     <= summing_nxt;
         gating_r      <= gating_nxt;
         prompted_r    <= prompted_nxt;
         start_r       <= start_nxt;
      end
   end

   // Pin outputs
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dac_load       <= 1'b0;
         ref_out_enable <= 1'b0;
         prompt_valid   <= 1'b0;
         prompt_data    <= 8'h0;
      end else if (ce) begin
         dac_load       <= dac_load_nxt;
         ref_out_enable <= !gating_nxt || locked_nxt;
         prompt_valid   <= prompt_nxt;
         prompt_data    <= prompt_nxt ? fsa_pkg::FW_VERSION : 8'h0;
      end
   end
endmodule : fsa_core
`default_nettype wire

// ---- bench/fsa_chk.sv ----
// Port checker for the loop averaging control block
`timescale 1ns/1ns
`default_nettype none
module fsa_chk #(
   parameter int unsigned POWERUP_CYCLES = 20,
   parameter int unsigned DAC_W          = 10
) (
   input wire logic             hclk,
   input wire logic             hresetn,
   input wire logic             ce,
   input wire logic             hsel,
   input wire logic [31:0]      haddr,
   input wire logic [1:0]       htrans,
   input wire logic             hwrite,
   input wire logic             hready,
   input wire logic [31:0]      hwdata,
   input wire logic [31:0]      hrdata,
   input wire logic [DAC_W-1:0] dac_value,
   input wire logic             dac_load,
   input wire logic             ref_out_enable,
   input wire logic             prompt_valid,
   input wire logic [7:0]       prompt_data
);
   int unsigned cyc_r;
   logic        wr_cmd_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cyc_r    <= 0;
         wr_cmd_r <= 1'b0;
      end else begin
         if (cyc_r < 1000) cyc_r <= cyc_r + 1;
         wr_cmd_r <= hsel && hready && htrans[1] && hwrite && ce &&
                     haddr[7:0] == fsa_pkg::REG_COMMAND;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // No further DAC update for 8 cycles after any DAC load
   sequence s_no_load;
      !dac_load [*8];
   endsequence
   chk_powerup_wait: assert property (prompt_valid |-> cyc_r >= POWERUP_CYCLES)
      else $error("prompt before power-up delay");
   chk_prompt_ver: assert property (prompt_valid |-> prompt_data == fsa_pkg::FW_VERSION)
      else $error("prompt byte wrong");
   chk_prompt_once: assert property (prompt_valid |=> !prompt_valid [*4])
      else $error("prompt repeated");
   chk_load_after: assert property (prompt_valid |-> ##[1:4] dac_load)
      else $error("no parameter load after prompt");
   chk_dac_pulse: assert property (!$stable(dac_value) |-> dac_load)
      else $error("dac changed without load pulse");
   chk_settle_gap: assert property (dac_load |=> s_no_load)
      else $error("dac reloaded too soon");
   chk_gate_off: assert property (wr_cmd_r &&
      hwdata[23:16] == fsa_pkg::OUTPUT_GATING_OFF_CMD |-> ##[1:2] ref_out_enable)
      else $error("outputs not enabled");
   chk_read_hold: assert property (!(hsel && hready && htrans[1] && !hwrite)
      |=> $stable(hrdata))
      else $error("read data moved");
endmodule : fsa_chk
bind fsa_core fsa_chk #(.POWERUP_CYCLES(POWERUP_CYCLES), .DAC_W(DAC_W)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .dac_value(dac_value), .dac_load(dac_load),
   .ref_out_enable(ref_out_enable), .prompt_valid(prompt_valid),
   .prompt_data(prompt_data));
`default_nettype wire

// ---- bench/fsa_ref_model.sv ----
// Reference tick source and parameter store, valid only while stored is high
`timescale 1ns/1ns
`default_nettype none
module fsa_ref_model #(
   parameter int unsigned TICK_DIV = 4
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic stored,
   output logic      ref_tick,
   output logic      nv_valid,
   output logic      nv_slope_neg,
   output logic      nv_summing,
   output logic      nv_gating_on,
   output logic [15:0] nv_cycle_size,
   output logic [15:0] nv_lock_limit,
   output logic [9:0]  nv_dac
);
   int unsigned div_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         div_r    <= 0;
         ref_tick <= 1'b0;
      end else begin
         div_r    <= (div_r == TICK_DIV - 1) ? 0 : div_r + 1;
         ref_tick <= (div_r == 0);
      end
   end
   // Stored set only while stored is high, else defaults apply
   assign nv_valid      = stored;
   assign nv_slope_neg  = 1'b1;
   assign nv_summing    = 1'b1;
   assign nv_gating_on  = 1'b1;
   assign nv_cycle_size = 16'h0003;
   assign nv_lock_limit = 16'h0007;
   assign nv_dac        = 10'h155;
endmodule : fsa_ref_model
`default_nettype wire

// ---- bench/testbench.sv ----
// Self-checking bench for the loop averaging control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic        hclk, hresetn, hwrite, hreadyout, hresp, ref_tick, nv_valid;
   logic        nv_slope_neg, nv_summing, nv_gating_on, dac_load, ref_out_enable;
   logic        prompt_valid, ce, nv_keep;
   logic [1:0]  htrans;
   logic [7:0]  prompt_data;
   logic [9:0]  nv_dac, dac_value;
   logic [15:0] nv_cycle_size, nv_lock_limit;
   logic [31:0] haddr, hwdata, hrdata, rd, s;
   int          bad_count, checked, n;
   always #5 hclk = ~hclk;
   fsa_core #(.POWERUP_CYCLES(20), .SAMPLE_CYCLES(50), .SETTLE_CYCLES(30)) dut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .ref_tick(ref_tick), .nv_valid(nv_valid), .nv_slope_neg(nv_slope_neg),
      .nv_summing(nv_summing), .nv_gating_on(nv_gating_on),
      .nv_cycle_size(nv_cycle_size), .nv_lock_limit(nv_lock_limit),
      .nv_dac(nv_dac), .dac_value(dac_value), .dac_load(dac_load),
      .ref_out_enable(ref_out_enable), .prompt_valid(prompt_valid),
      .prompt_data(prompt_data));
   fsa_ref_model u_ref (
      .hclk(hclk), .hresetn(hresetn), .ref_tick(ref_tick), .nv_valid(nv_valid),
      .nv_slope_neg(nv_slope_neg), .nv_summing(nv_summing),
      .nv_gating_on(nv_gating_on), .nv_cycle_size(nv_cycle_size),
      .nv_lock_limit(nv_lock_limit), .nv_dac(nv_dac), .stored(nv_keep));
   task end_sim;
      if (bad_count == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   task fail_wait;
      bad_count++;
      $display("ERROR %0t wait timed out", $time);
      end_sim();
   endtask : fail_wait
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task wait_rdy;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) fail_wait();
   endtask : wait_rdy
   // One single-word transfer; read data lands in rd
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'b00;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask : xfer
   task rdr(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask : rdr
   task cmd(input logic [7:0] op, input logic [15:0] arg);
      xfer(1'b1, fsa_pkg::REG_COMMAND, {8'h00, op, arg});
   endtask : cmd
   task wait_load;
      int k;
      k = 0;
      do begin
         @(negedge hclk);
         k++;
      end while (dac_load !== 1'b1 && k < 400);
      if (dac_load !== 1'b1) fail_wait();
   endtask : wait_load
   // Poll until the first sample of a fresh cycle is in
   task wait_first;
      int k;
      k = 0;
      do begin
         rdr(fsa_pkg::REG_SAMPLE);
         k++;
      end while (rd[31:16] !== 16'h0001 && k < 300);
      if (rd[31:16] !== 16'h0001) fail_wait();
   endtask : wait_first
   initial begin
      hclk = 0; hresetn = 0; haddr = 0; htrans = 0; hwrite = 0; hwdata = 0;
      ce = 1;
      nv_keep = 0;
      bad_count = 0; checked = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (prompt_valid !== 1'b1 && n < 100);
      chk(32'(n >= 20 && n < 100), 32'h1);
      chk(32'(prompt_data), 32'(fsa_pkg::FW_VERSION));
      wait_load();
      chk(32'(dac_value), 32'(fsa_pkg::DAC_MID_SCALE));
      chk(32'(ref_out_enable), 32'h1);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[6:0]), 32'h40);
      rdr(fsa_pkg::REG_CYCLE_SIZE); chk(rd, 32'h000A);
      rdr(fsa_pkg::REG_LOCK_LIMIT); chk(rd, 32'h0002);
      xfer(1'b1, fsa_pkg::REG_VERSION, 32'h0);
      rdr(fsa_pkg::REG_VERSION); chk(rd, 32'h11);
      rdr(8'h40); chk(rd, 32'h0);
      xfer(1'b1, fsa_pkg::REG_CYCLE_SIZE, 32'h2);
      wait_first(); rdr(fsa_pkg::REG_ACCUM); chk(rd, 32'hFFFFFFFF);
      wait_load(); chk(32'(dac_value), 32'h201);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[5]), 32'h1);
      wait_first(); rdr(fsa_pkg::REG_ACCUM); chk(rd, 32'hFFFFFFFF);
      cmd(fsa_pkg::SLOPE_NEGATIVE_CMD, 16'h0);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[2]), 32'h1);
      wait_load(); chk(32'(dac_value), 32'h200);
      cmd(fsa_pkg::SUMMING_MODE_CMD, 16'h0);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[3]), 32'h1);
      wait_first(); s = rd;
      rdr(fsa_pkg::REG_ACCUM); chk(rd, {16'h0, s[15:0]} - 32'h6800);
      cmd(fsa_pkg::DISABLE_CMD, 16'h0);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[1]), 32'h1);
      cmd(fsa_pkg::TUNE_CMD, 16'h0123);
      wait_load(); chk(32'(dac_value), 32'h123);
      cmd(fsa_pkg::ENABLE_CMD, 16'h0);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[1]), 32'h0);
      cmd(fsa_pkg::TUNE_CMD, 16'h0055);
      repeat (3) @(negedge hclk);
      chk(32'(dac_value), 32'h123);
      cmd(fsa_pkg::OUTPUT_GATING_ON_CMD, 16'h0);
      repeat (2) @(negedge hclk);
      chk(32'(ref_out_enable), 32'h0);
      // A command sent while the clock enable is low must be lost
      @(posedge hclk);
      ce <= 1'b0;
      cmd(fsa_pkg::OUTPUT_GATING_OFF_CMD, 16'h0);
      ce <= 1'b1;
      repeat (2) @(negedge hclk);
      chk(32'(ref_out_enable), 32'h0);
      cmd(fsa_pkg::OUTPUT_GATING_OFF_CMD, 16'h0);
      repeat (2) @(negedge hclk);
      chk(32'(ref_out_enable), 32'h1);
      cmd(fsa_pkg::SLOPE_POSITIVE_CMD, 16'h0);
      cmd(fsa_pkg::VOTING_MODE_CMD, 16'h0);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[3:2]), 32'h0);
      // Reset again with a stored parameter set present
      hresetn <= 1'b0;
      nv_keep <= 1'b1;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      wait_load(); chk(32'(dac_value), 32'h155);
      chk(32'(ref_out_enable), 32'h0);
      rdr(fsa_pkg::REG_STATUS); chk(32'(rd[6:0]), 32'h5C);
      rdr(fsa_pkg::REG_CYCLE_SIZE); chk(rd, 32'h0003);
      end_sim();
   end
endmodule : testbench
`default_nettype wire
